// [logic/rel_params.svh]
/*
  Constants of the recoverable error logger: register indices, error
  code pieces and reset values.
  Assumes it is included by bare name from files that use the macros.
*/
`ifndef REL_PARAMS_SVH
`define REL_PARAMS_SVH

// Register indices, low nibble of the register address
`define R_CTRL    4'h0
`define R_STAT    4'h1
`define R_MISC    4'h2
`define R_ADLO    4'h3
`define R_ADHI    4'h4
`define R_GLOB    4'h5
`define R_IRQS    4'h6
`define R_IMSK    4'h7

// Memory controller code: 0000_0000_1 then memory type then channel
`define MEM_CLASS 9'h001
`define MMM_SCRUB 3'h4
`define CH_MAX    4'he
`define CH_NONE   4'hf

// Cache hierarchy code: 0000_0001 then request, type, level
`define CACHE_CLASS 8'h01
`define REQ_DRD   4'h3
`define REQ_IRD   4'h5
`define REQ_EVICT 4'h7
`define TT_INSTR  2'h0
`define TT_DATA   2'h1
`define TT_GEN    2'h2
`define LL_ZERO   2'h0
`define LL_TWO    2'h2

// Miscellaneous register address mode: physical
`define MODE_PHYS 3'h2

// Reset values
`define RST_WORD  32'h0000_0000

`endif

// [logic/rel_pkg.sv]
/*
  Types shared by the recoverable error logger and its helpers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rel_pkg;

  // Four architected recoverable errors
  typedef enum logic [1:0] {
    K_SCRUB = 2'h0,
    K_WBACK = 2'h1,
    K_LOAD  = 2'h2,
    K_FETCH = 2'h3
  } err_kind_t;

  // One detected error as the detector hands it over
  typedef struct packed {
    err_kind_t  kind;
    logic [3:0] channel;
    logic       chan_known;
    logic       via_corr_int;
    logic       continuable;
    logic [5:0] addr_lsb;
  } err_event_t;

  // Bank status word
  typedef struct packed {
    logic [6:0]  rsvd;
    logic        valid;
    logic        overflow;
    logic        uncorrected_flag;
    logic        report_gate;
    logic        misc_info_valid;
    logic        address_info_valid;
    logic        context_corrupt_flag;
    logic        signalled;
    logic        action_needed_flag;
    logic [15:0] error_code_field;
  } bank_status_t;

  // Bank miscellaneous word
  typedef struct packed {
    logic [22:0] rsvd;
    logic [2:0]  addr_mode;
    logic [5:0]  addr_lsb;
  } bank_misc_t;

  // Per-processor global status word
  typedef struct packed {
    logic [28:0] rsvd;
    logic        local_delivery_status;
    logic        error_ip_valid;
    logic        restart_ip_valid;
  } global_check_status_t;

  // Control word
  typedef struct packed {
    logic [30:0] rsvd;
    logic        local_check_delivery;
  } ctrl_reg_t;

  // Interrupt status and mask words
  typedef struct packed {
    logic [28:0] rsvd;
    logic        dropped;
    logic        req_logged;
    logic        opt_logged;
  } irq_bits_t;

  // Action-optional kinds: scrub and writeback
  function automatic logic is_opt(input err_kind_t k);
    return (k == K_SCRUB) || (k == K_WBACK);
  endfunction

endpackage

// [logic/code_builder.sv]
/*
  Builds the 16-bit error code for each of the four error kinds.
  Assumes channel numbers come straight from the memory controller.
*/
`include "rel_params.svh"

module code_builder (
  // Error description
  input  wire rel_pkg::err_kind_t kind,
  input  wire logic [3:0]         channel,
  input  wire logic               chan_known,
  // Composed code
  output logic [15:0]             code
);

  logic [3:0] chan;

  // Unknown or out-of-range channel reads as not specified
  assign chan = (chan_known && channel <= `CH_MAX) ? channel : `CH_NONE;

  // Compose from subfields so each code keeps its documented shape
  always_comb begin
    unique case (kind)
      rel_pkg::K_SCRUB: code = {`MEM_CLASS, `MMM_SCRUB, chan};
      rel_pkg::K_WBACK: code = {`CACHE_CLASS, `REQ_EVICT, `TT_GEN, `LL_TWO};
      rel_pkg::K_LOAD:  code = {`CACHE_CLASS, `REQ_DRD, `TT_DATA, `LL_ZERO};
      rel_pkg::K_FETCH: code = {`CACHE_CLASS, `REQ_IRD, `TT_INSTR, `LL_ZERO};
    endcase
  end

endmodule

// [logic/proc_flags.sv]
/*
  Per-processor restart and error pointer flags for one signalled error.
  Assumes the caller applies them only to processors that get the check.
*/
module proc_flags #(
  parameter int NPROC = 4,
  parameter int PW    = $clog2(NPROC)
) (
  // Error description
  input  wire rel_pkg::err_kind_t kind,
  input  wire logic               continuable,
  input  wire logic [PW-1:0]      who,
  // Flag values per processor
  output logic [NPROC-1:0]        restart,
  output logic [NPROC-1:0]        errip
);

  // Only the affected processor of an action-required error differs
  always_comb begin
    for (int i = 0; i < NPROC; i++) begin
      if (!rel_pkg::is_opt(kind) && i == int'(who)) begin
        restart[i] = continuable;
        errip[i]   = continuable;
      end else begin
        restart[i] = 1'b1;
        errip[i]   = 1'b0;
      end
    end
  end

endmodule

// [logic/error_logger.sv]
/*
  Recoverable error logger: one shared status bank, per-processor
  global status, check delivery and a register port for software.
  Assumes error events are synchronous to mclk and one cycle long.
*/
`include "rel_params.svh"

module error_logger #(
  parameter int               NPROC      = 4,
  parameter int               PW         = $clog2(NPROC),
  parameter int               AW         = 40,
  parameter logic [NPROC-1:0] SHARE_MASK = NPROC'(3),
  parameter bit               LOCAL_SUP  = 1'b1
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  // Error detection
  input  wire logic                 err_valid,
  input  wire rel_pkg::err_event_t  err_ev,
  input  wire logic [PW-1:0]        err_proc,
  input  wire logic [AW-1:0]        err_addr,
  // Register port
  input  wire logic [7:0]           addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic [31:0]               rd_data_q,
  // Delivery
  output logic [NPROC-1:0]          check_exc_q,
  output logic                      corr_int_q,
  output logic                      irq_q
);

  rel_pkg::bank_status_t stat_q;
  rel_pkg::bank_misc_t   misc_q;
  rel_pkg::bank_misc_t   misc_d;
  rel_pkg::ctrl_reg_t    ctrl_q;
  rel_pkg::irq_bits_t    irqs_q;
  rel_pkg::irq_bits_t    imsk_q;
  rel_pkg::irq_bits_t    evt;
  logic [63:0]           baddr_q;
  logic [63:0]           baddr_d;
  logic [NPROC-1:0]      restart_q;
  logic [NPROC-1:0]      errip_q;
  logic [NPROC-1:0]      lds_q;
  logic [NPROC-1:0]      restart_n;
  logic [NPROC-1:0]      errip_n;
  logic [NPROC-1:0]      targ;
  logic [15:0]           code;
  logic [3:0]            psel;
  logic [3:0]            ridx;
  logic [31:0]           rdval;
  logic                  opt;
  logic                  take;
  logic                  sig_chk;
  logic                  local_d;

  // Does processor p share the bank
  function automatic logic sees(input logic [3:0] p);
    return (int'(p) < NPROC) && SHARE_MASK[p[PW-1:0]];
  endfunction

  // Status word for a freshly logged error
  function automatic rel_pkg::bank_status_t make_status(
      input rel_pkg::err_event_t ev, input logic [15:0] c);
    rel_pkg::bank_status_t s;
    logic                  sg;
    s  = '0;
    sg = !rel_pkg::is_opt(ev.kind) || !ev.via_corr_int;
    s.valid                = 1'b1;
    s.uncorrected_flag     = 1'b1;
    s.misc_info_valid      = 1'b1;
    s.address_info_valid   = 1'b1;
    s.overflow             = 1'b0;
    s.context_corrupt_flag = 1'b0;
    s.action_needed_flag   = !rel_pkg::is_opt(ev.kind);
    s.report_gate          = sg;
    s.signalled            = sg;
    s.error_code_field     = c;
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Event decode

  code_builder u_code (
    .kind       (err_ev.kind),
    .channel    (err_ev.channel),
    .chan_known (err_ev.chan_known),
    .code       (code)
  );

  proc_flags #(.NPROC(NPROC), .PW(PW)) u_flags (
    .kind        (err_ev.kind),
    .continuable (err_ev.continuable),
    .who         (err_proc),
    .restart     (restart_n),
    .errip       (errip_n)
  );

  // A full bank drops new errors rather than overwrite the record
  assign psel    = addr[7:4];
  assign ridx    = addr[3:0];
  assign opt     = rel_pkg::is_opt(err_ev.kind);
  assign take    = err_valid && !stat_q.valid;
  assign sig_chk = take && !(opt && err_ev.via_corr_int);
  assign local_d = ctrl_q.local_check_delivery && LOCAL_SUP;
  assign targ    = local_d ? (NPROC'(1) << err_proc) : '1;

  // Misc word and address trimmed below the lowest valid bit
  always_comb begin
    misc_d           = '0;
    misc_d.addr_mode = `MODE_PHYS;
    misc_d.addr_lsb  = err_ev.addr_lsb;
    baddr_d          = 64'(err_addr) & ~((64'h1 << err_ev.addr_lsb) - 64'h1);
  end

  ////////////////////////////////////////////////////////////////////
  // Error record: one edge writes all three words

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      stat_q  <= '0;
      misc_q  <= '0;
      baddr_q <= '0;
    end else if (take) begin
      stat_q  <= make_status(err_ev, code);
      misc_q  <= misc_d;
      baddr_q <= baddr_d;
    end else if (wr && ridx == `R_STAT && sees(psel)) begin
      stat_q  <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Per-processor global status; a new signal wins over software

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      restart_q <= '0;
      errip_q   <= '0;
      lds_q     <= '0;
    end else begin
      for (int i = 0; i < NPROC; i++) begin
        if (sig_chk && targ[i]) begin
          restart_q[i] <= restart_n[i];
          errip_q[i]   <= errip_n[i];
          lds_q[i]     <= local_d;
        end else if (wr && ridx == `R_GLOB && int'(psel) == i) begin
          restart_q[i] <= wdata[0];
          errip_q[i]   <= wdata[1];
          lds_q[i]     <= wdata[2];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Delivery pulses

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      check_exc_q <= '0;
      corr_int_q  <= 1'b0;
    end else begin
      check_exc_q <= sig_chk ? targ : '0;
      corr_int_q  <= take && opt && err_ev.via_corr_int;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control and interrupt registers; set beats write-one-to-clear

  always_comb begin
    evt            = '0;
    evt.opt_logged = take && opt;
    evt.req_logged = take && !opt;
    evt.dropped    = err_valid && stat_q.valid;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl_q <= `RST_WORD;
      imsk_q <= `RST_WORD;
      irqs_q <= `RST_WORD;
      irq_q  <= 1'b0;
    end else begin
      if (wr && ridx == `R_CTRL) begin
        ctrl_q                      <= '0;
        ctrl_q.local_check_delivery <= wdata[0];
      end
      if (wr && ridx == `R_IMSK) begin
        imsk_q <= {29'h0, wdata[2:0]};
      end
      if (wr && ridx == `R_IRQS) begin
        irqs_q <= (irqs_q & ~{29'h0, wdata[2:0]}) | evt;
      end else begin
        irqs_q <= irqs_q | evt;
      end
      // One cycle behind the sticky bits; keeps the output a flop
      irq_q <= |(irqs_q & imsk_q);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read path; bank words only for processors sharing the bank

  always_comb begin
    rdval = '0;
    unique case (ridx)
      `R_CTRL: rdval = ctrl_q;
      `R_STAT: rdval = sees(psel) ? stat_q : '0;
      `R_MISC: rdval = sees(psel) ? misc_q : '0;
      `R_ADLO: rdval = sees(psel) ? baddr_q[31:0] : '0;
      `R_ADHI: rdval = sees(psel) ? baddr_q[63:32] : '0;
      `R_GLOB: begin
        if (int'(psel) < NPROC) begin
          rdval = {29'h0, lds_q[psel[PW-1:0]], errip_q[psel[PW-1:0]],
                   restart_q[psel[PW-1:0]]};
        end
      end
      `R_IRQS: rdval = irqs_q;
      `R_IMSK: rdval = imsk_q;
      default: rdval = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd ? rdval : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence s_take(rel_pkg::err_kind_t k);
    take && err_ev.kind == k;
  endsequence

  sequence s_record;
    stat_q.valid && stat_q.misc_info_valid && stat_q.address_info_valid;
  endsequence

  chk_scrub_code: assert property (
    s_take(rel_pkg::K_SCRUB) |=> stat_q.error_code_field[15:4] == 12'h00c)
    else $error("scrub code prefix wrong");
  chk_wback_code: assert property (
    s_take(rel_pkg::K_WBACK) |=> stat_q.error_code_field == 16'h017a)
    else $error("writeback code wrong");
  chk_load_code: assert property (
    s_take(rel_pkg::K_LOAD) |=> stat_q.error_code_field == 16'h0134)
    else $error("data load code wrong");
  chk_fetch_code: assert property (
    s_take(rel_pkg::K_FETCH) |=> stat_q.error_code_field == 16'h0150)
    else $error("instruction fetch code wrong");
  chk_opt_flags: assert property (
    take && opt |=> s_record and (stat_q.uncorrected_flag && !stat_q.overflow
      && !stat_q.context_corrupt_flag && !stat_q.action_needed_flag))
    else $error("optional error flags wrong");
  chk_opt_path: assert property (
    take && opt && err_ev.via_corr_int |=> !stat_q.signalled && corr_int_q
      && check_exc_q == '0)
    else $error("interrupt path marked as signalled");
  chk_req_flags: assert property (
    take && !opt |=> s_record and (stat_q.report_gate && stat_q.signalled
      && stat_q.action_needed_flag && !stat_q.overflow && !stat_q.context_corrupt_flag))
    else $error("required error flags wrong");
  chk_addr_capture: assert property (
    take |=> s_record and (baddr_q == $past(baddr_d)))
    else $error("address not captured");
  chk_misc_mode: assert property (
    take |=> misc_q.addr_mode == 3'h2 && misc_q.addr_lsb == $past(err_ev.addr_lsb))
    else $error("misc mode or lsb wrong");
  chk_broadcast: assert property (
    sig_chk && !local_d |=> check_exc_q == '1 ##1 check_exc_q == '0)
    else $error("check not broadcast");
  chk_opt_global: assert property (
    sig_chk && opt && !local_d |=> restart_q == '1 && errip_q == '0)
    else $error("optional global flags wrong");
  chk_req_affected: assert property (
    sig_chk && !opt && err_ev.continuable |=> restart_q[$past(err_proc)]
      && errip_q[$past(err_proc)])
    else $error("affected processor flags wrong");
  chk_share_view: assert property (
    rd && ridx == `R_STAT && !sees(psel) |=> rd_data_q == '0)
    else $error("unshared processor sees bank");
  chk_channel_none: assert property (
    (s_take(rel_pkg::K_SCRUB) and !err_ev.chan_known) |=>
      stat_q.error_code_field[3:0] == 4'hf)
    else $error("unknown channel not marked");
  chk_atomic: assert property (
    !take |=> $stable(misc_q) && $stable(baddr_q))
    else $error("record words changed apart");

endmodule

// [test/error_logger_bench.sv]
/*
  Self-checking bench for the recoverable error logger.
  Assumes the default parameters: four processors, bank shared by
  processors 0 and 1, local delivery supported, 40-bit addresses.
*/
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module error_logger_bench;
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////////
  // Design inputs, all given a value at time zero
  logic                mclk      = 1'b0;
  logic                nrst      = 1'b0;
  logic                err_valid = 1'b0;
  rel_pkg::err_event_t err_ev    = '0;
  logic [1:0]          err_proc  = 2'h0;
  logic [39:0]         err_addr  = 40'h0;
  logic [7:0]          addr      = 8'h00;
  logic [31:0]         wdata     = 32'h0;
  logic                wr        = 1'b0;
  logic                rd        = 1'b0;
  logic [31:0]         rd_data_q;
  logic [3:0]          check_exc_q;
  logic                corr_int_q;
  logic                irq_q;
  int                  n_fail      = 0;
  int                  check_count = 0;

  error_logger i_dut (
    .mclk        (mclk),
    .nrst        (nrst),
    .err_valid   (err_valid),
    .err_ev      (err_ev),
    .err_proc    (err_proc),
    .err_addr    (err_addr),
    .addr        (addr),
    .wdata       (wdata),
    .wr          (wr),
    .rd          (rd),
    .rd_data_q   (rd_data_q),
    .check_exc_q (check_exc_q),
    .corr_int_q  (corr_int_q),
    .irq_q       (irq_q)
  );

  // 20 MHz core clock
  always #25 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  // Status word from its flags; overflow and context corrupt always clear
  // Codes keep bit 12 clear here; a software decoder ignores that bit
  function automatic logic [31:0] stat_w(logic gate, logic sig, logic act, logic [15:0] c);
    return {7'h0, 1'b1, 1'b0, 1'b1, gate, 1'b1, 1'b1, 1'b0, sig, act, c};
  endfunction

  // One write cycle, strobe dropped after the taking edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  // One read cycle; data judged in the single cycle it stands
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    `CHK(nm, e, rd_data_q)
  endtask

  // One error pulse; delivery pulses judged one cycle later, then the check pulse judged gone
  task automatic inj(input rel_pkg::err_kind_t k, input logic [3:0] ch, input logic kn,
                     input logic vc, input logic ct, input logic [5:0] lsb,
                     input logic [1:0] p, input logic [39:0] a,
                     input logic [3:0] e_chk, input logic e_corr);
    @(posedge mclk);
    err_valid <= 1'b1;
    err_ev    <= '{k, ch, kn, vc, ct, lsb};
    err_proc  <= p;
    err_addr  <= a;
    @(posedge mclk);
    err_valid <= 1'b0;
    #1;
    `CHK("check pulse", e_chk, check_exc_q)
    `CHK("corr pulse", e_corr, corr_int_q)
    @(posedge mclk);
    #1;
    `CHK("check pulse end", 4'h0, check_exc_q)
  endtask

  // Whole record read back, then released by a status write
  task automatic rec(input logic [31:0] e_st, input logic [5:0] lsb, input logic [39:0] a);
    logic [63:0] ea;
    ea = ({24'h0, a} >> lsb) << lsb;
    rd_reg(8'h01, e_st, "status");
    rd_reg(8'h02, {23'h0, 3'h2, lsb}, "misc");
    rd_reg(8'h03, ea[31:0], "addr lo");
    rd_reg(8'h04, ea[63:32], "addr hi");
    wr_reg(8'h01, 32'h0);
    rd_reg(8'h01, 32'h0, "status cleared");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rd_reg(8'h00, 32'h0, "ctrl rst");
    rd_reg(8'h01, 32'h0, "status rst");
    rd_reg(8'h05, 32'h0, "global rst");
    rd_reg(8'h07, 32'h0, "mask rst");
    wr_reg(8'h0a, 32'hffff_ffff);
    rd_reg(8'h0a, 32'h0, "unmapped");
    $display("test reset done");
  endtask

  // Scrub by check: broadcast, drop while full, interrupt mask and clear
  task automatic t_scrub();
    inj(rel_pkg::K_SCRUB, 4'h5, 1'b1, 1'b0, 1'b0, 6'hc, 2'h0, 40'h12_3456_789a,
        4'hf, 1'b0);
    rd_reg(8'h05, 32'h1, "glob p0");
    rd_reg(8'h35, 32'h1, "glob p3");
    rd_reg(8'h21, 32'h0, "unshared bank");
    rd_reg(8'h11, stat_w(1'b1, 1'b1, 1'b0, 16'h00c5), "shared bank");
    inj(rel_pkg::K_LOAD, 4'h0, 1'b1, 1'b0, 1'b1, 6'h0, 2'h1, 40'h0, 4'h0, 1'b0);
    rd_reg(8'h06, 32'h5, "irq drop");
    rd_reg(8'h15, 32'h1, "glob after drop");
    wr_reg(8'h07, 32'h1);
    @(posedge mclk);
    #1;
    `CHK("irq on", 1'b1, irq_q)
    wr_reg(8'h06, 32'h7);
    @(posedge mclk);
    #1;
    `CHK("irq off", 1'b0, irq_q)
    rd_reg(8'h06, 32'h0, "irq cleared");
    rec(stat_w(1'b1, 1'b1, 1'b0, 16'h00c5), 6'hc, 40'h12_3456_789a);
    $display("test scrub done");
  endtask

  // Writeback by corrected interrupt, and the channel field boundaries
  task automatic t_corr();
    logic [3:0]  ch [4] = '{4'h0, 4'he, 4'hf, 4'h3};
    logic        kn [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic [15:0] cd [4] = '{16'h00c0, 16'h00ce, 16'h00cf, 16'h00cf};
    inj(rel_pkg::K_WBACK, 4'h0, 1'b1, 1'b1, 1'b0, 6'h6, 2'h0, 40'hab_cdef_0123,
        4'h0, 1'b1);
    rec(stat_w(1'b0, 1'b0, 1'b0, 16'h017a), 6'h6, 40'hab_cdef_0123);
    for (int i = 0; i < 4; i++) begin
      inj(rel_pkg::K_SCRUB, ch[i], kn[i], 1'b1, 1'b0, 6'h0, 2'h0, 40'h1, 4'h0, 1'b1);
      rec(stat_w(1'b0, 1'b0, 1'b0, cd[i]), 6'h0, 40'h1);
    end
    $display("test corrected done");
  endtask

  // Load with local delivery, then fetch broadcast and not continuable
  task automatic t_req();
    wr_reg(8'h00, 32'h1);
    inj(rel_pkg::K_LOAD, 4'h0, 1'b1, 1'b0, 1'b1, 6'h6, 2'h1, 40'h00_8000_0fc0,
        4'h2, 1'b0);
    rd_reg(8'h15, 32'h7, "glob local");
    rec(stat_w(1'b1, 1'b1, 1'b1, 16'h0134), 6'h6, 40'h00_8000_0fc0);
    wr_reg(8'h00, 32'h0);
    inj(rel_pkg::K_FETCH, 4'h0, 1'b1, 1'b0, 1'b0, 6'h3f, 2'h2, 40'hff_ffff_ffff,
        4'hf, 1'b0);
    rd_reg(8'h25, 32'h0, "glob affected");
    rd_reg(8'h05, 32'h1, "glob other");
    rd_reg(8'h06, 32'h3, "irq required");
    rec(stat_w(1'b1, 1'b1, 1'b1, 16'h0150), 6'h3f, 40'hff_ffff_ffff);
    $display("test required done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or the watchdog
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_scrub();
    t_corr();
    t_req();
    summarize();
  end

  // Watchdog, far beyond the 183 cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    summarize();
  end
endmodule
